/* rtl/ucc_host.sv */
// Controller end: takes register commands over APB and runs them on the
// configuration block's register port. Assumes one clock, APB on CLK_SYS.
`timescale 1ns/1ps
module ucc_host import ucc_pkg::*; (
    input wire logic CLK_SYS,
    input wire logic RST,
    ucc_link_if.host LINK,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ
);

    ucc_hstate_e state;
    logic [15:0] cmd_addr;
    logic [15:0] cmd_wdata;
    logic cmd_write;
    logic [15:0] result;
    logic [7:0] last_index;
    logic [3:0] guard_cnt;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [15:0] out_wdata;

    // APB phases; the slave is ready in the first access cycle
    wire setup = PSEL & !PENABLE;
    wire apb_wr = PSEL & PENABLE & PREADY & PWRITE;
    wire busy = (state != HS_IDLE);
    wire sel_addr = (PADDR == HOST_ADDR);
    wire sel_wdata = (PADDR == HOST_WDATA);
    wire sel_ctrl = (PADDR == HOST_CTRL);
    wire sel_result = (PADDR == HOST_RESULT);
    wire sel_stat = (PADDR == HOST_INT_STAT);
    wire sel_mask = (PADDR == HOST_INT_MASK);
    wire mapped = sel_addr | sel_wdata | sel_ctrl | sel_result | sel_stat | sel_mask;
    wire start = apb_wr & sel_ctrl & PWDATA[CTRL_START] & !busy;
    wire [31:0] rd_mux = sel_addr ? {16'h0000, cmd_addr} :
                         sel_wdata ? {16'h0000, cmd_wdata} :
                         sel_ctrl ? {30'h00000000, cmd_write, busy} :
                         sel_result ? {15'h0000, busy, result} :
                         sel_stat ? {29'h00000000, int_stat} :
                         sel_mask ? {29'h00000000, int_mask} : 32'h00000000;

    // Command target as seen through the shadow of the device index
    wire tgt_index = (cmd_addr == ADDR_EXT_INDEX);
    wire tgt_data = (cmd_addr == ADDR_EXT_DATA);
    wire tgt_toggle = tgt_data & (last_index == IDX_TOGGLE);
    wire hold = !cmd_write & tgt_toggle & (guard_cnt != 4'h0);
    wire coerced = cmd_write & (out_wdata != cmd_wdata);
    wire launch = (state == HS_GUARD) & !hold;
    wire done = (state == HS_WAIT) & LINK.ack;

    // Outgoing write data is cleaned so the device never sees an illegal value
    always_comb begin
        out_wdata = cmd_wdata;
        if (cmd_addr == ADDR_INPUT_CTL) begin
            out_wdata = cmd_wdata & WMASK_INPUT_CTL;
        end else if (cmd_addr == ADDR_RSVD_A) begin
            out_wdata = 16'h0000;
        end else if (tgt_data) begin
            case (last_index)
                IDX_TOGGLE: out_wdata = cmd_wdata & {8'h00, WMASK_TOGGLE};
                IDX_RSVD: out_wdata = 16'h0000;
                IDX_MAX_CUR: out_wdata = (cmd_wdata > {8'h00, MAX_CUR_LIMIT}) ?
                                         {8'h00, MAX_CUR_LIMIT} : cmd_wdata;
                IDX_TXAE_THR: out_wdata = (cmd_wdata[7:0] == 8'h00) ? {8'h00, TXAE_MIN} :
                                          {8'h00, cmd_wdata[7:0]};
                default: out_wdata = cmd_wdata;
            endcase
        end
    end

    // Sticky events; a new event wins over a same-cycle clear
    wire [2:0] int_set = {launch & coerced, (state == HS_GUARD) & hold, done};
    wire [2:0] int_clr = (apb_wr & sel_stat) ? PWDATA[2:0] : 3'h0;
    wire [2:0] next_int_stat = (int_stat & ~int_clr) | int_set;

    // APB answer registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            PREADY <= 1'h0;
            PSLVERR <= 1'h0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= setup;
            PSLVERR <= setup & !mapped;
            if (setup) begin
                PRDATA <= rd_mux;
            end
        end
    end

    // Software registers; command fields are frozen while a command runs
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cmd_addr <= 16'h0000;
            cmd_wdata <= 16'h0000;
            cmd_write <= 1'h0;
            int_mask <= 3'h0;
            int_stat <= 3'h0;
            IRQ <= 1'h0;
        end else begin
            if (apb_wr && sel_addr && !busy) begin
                cmd_addr <= PWDATA[15:0];
            end
            if (apb_wr && sel_wdata && !busy) begin
                cmd_wdata <= PWDATA[15:0];
            end
            if (start) begin
                cmd_write <= PWDATA[CTRL_WRITE];
            end
            if (apb_wr && sel_mask) begin
                int_mask <= PWDATA[2:0];
            end
            int_stat <= next_int_stat;
            IRQ <= |(next_int_stat & int_mask);
        end
    end

    // Toggle settle guard, armed when a toggle write is acknowledged
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            guard_cnt <= 4'h0;
        end else if (done && cmd_write && tgt_toggle) begin
            guard_cnt <= TOGGLE_SETTLE_CYC;
        end else if (guard_cnt != 4'h0) begin
            guard_cnt <= guard_cnt - 4'h1;
        end
    end

    // Command sequencer; a read of the toggles waits out the guard first
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state <= HS_IDLE;
            LINK.sel <= 1'h0;
            LINK.write <= 1'h0;
            LINK.addr <= 16'h0000;
            LINK.wdata <= 16'h0000;
            result <= 16'h0000;
            last_index <= RST_INDEX;
        end else begin
            LINK.sel <= launch;
            case (state)
                HS_IDLE: begin
                    if (start) begin
                        state <= HS_GUARD;
                    end
                end
                HS_GUARD: begin
                    if (!hold) begin
                        LINK.write <= cmd_write;
                        LINK.addr <= cmd_addr;
                        LINK.wdata <= out_wdata;
                        state <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (LINK.ack) begin
                        state <= HS_IDLE;
                        if (!cmd_write) begin
                            result <= LINK.rdata;
                        end
                        if (cmd_write && tgt_index) begin
                            last_index <= out_wdata[7:0];
                        end
                    end
                end
                default: state <= HS_IDLE;
            endcase
        end
    end

endmodule

/* rtl/ucc_pkg.sv */
// Shared constants for the USB client configuration register block and its controller.
// Assumes one system clock; both ends import this package whole.
// Contract
// - Transmit almost-empty threshold is never programmed zero
// - String enable selects string indexes, else zero
// - Max current in 2 mA, at most FAh
// - EP4 toggle is sent on next IN
// - EP3 toggle is expected on next OUT data
// - EP2 toggle is sent on next IN
// - EP1 toggle is expected on next OUT data
// - Wait twelve clocks before toggle readback
// - Reserved bits are always written zero
// - Qualify mode: EP4 NAKs unless FIFO valid
// - Plain mode: EP4 sends waiting data, ignores valid
// - Receiver enable bit switches differential receiver
// - Transfer type bit: isochronous zero, bulk one
// - Remote wake-up bit is active low
// - Data port goes to last written index
package ucc_pkg;
    // Device register port addresses
    localparam logic [15:0] ADDR_EXT_INDEX = 16'h4038;
    localparam logic [15:0] ADDR_EXT_DATA = 16'h403A;
    localparam logic [15:0] ADDR_INPUT_CTL = 16'h4040;
    localparam logic [15:0] ADDR_RSVD_A = 16'h4042;
    // Extended register indexes
    localparam logic [7:0] IDX_TXAE_THR = 8'h07;
    localparam logic [7:0] IDX_STRING = 8'h08;
    localparam logic [7:0] IDX_MAX_CUR = 8'h09;
    localparam logic [7:0] IDX_TOGGLE = 8'h0A;
    localparam logic [7:0] IDX_RSVD = 8'h0B;
    localparam logic [7:0] IDX_FIFO_CTL = 8'h0C;
    // Values after reset
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] RST_STRING = 8'h01;
    localparam logic [7:0] RST_MAX_CUR = 8'hFA;
    localparam logic [7:0] RST_TOGGLE = 8'h00;
    localparam logic [7:0] RST_RSVD_EXT = 8'h00;
    localparam logic [7:0] RST_FIFO_CTL = 8'h00;
    localparam logic [15:0] RST_INPUT_CTL = 16'h000D;
    // Field positions and limits
    localparam int BIT_STRING_EN = 0;
    localparam int BIT_TXQ_MODE = 0;
    localparam int BIT_DIFF_RX = 6;
    localparam int BIT_BULK = 3;
    localparam int BIT_WAKE_N = 2;
    localparam int TOGGLE_LSB = 4;
    localparam logic [7:0] MAX_CUR_LIMIT = 8'hFA;
    localparam logic [7:0] TXAE_MIN = 8'h01;
    localparam logic [7:0] WMASK_TOGGLE = 8'hF0;
    localparam logic [15:0] WMASK_INPUT_CTL = 16'h004C;
    localparam logic [7:0] STR_IDX_VENDOR = 8'h01;
    localparam logic [7:0] STR_IDX_PRODUCT = 8'h02;
    // Toggle readback settle time, in usb_side_clock cycles (same as CLK_SYS here)
    localparam logic [3:0] TOGGLE_SETTLE_CYC = 4'hC;
    // Controller APB map
    localparam logic [7:0] HOST_ADDR = 8'h00;
    localparam logic [7:0] HOST_WDATA = 8'h04;
    localparam logic [7:0] HOST_CTRL = 8'h08;
    localparam logic [7:0] HOST_RESULT = 8'h0C;
    localparam logic [7:0] HOST_INT_STAT = 8'h10;
    localparam logic [7:0] HOST_INT_MASK = 8'h14;
    localparam int CTRL_START = 0;
    localparam int CTRL_WRITE = 1;
    localparam int INT_DONE = 0;
    localparam int INT_HELD = 1;
    localparam int INT_COERCED = 2;
    // Controller sequencer states
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_GUARD = 2'b01,
        HS_WAIT = 2'b10
    } ucc_hstate_e;
endpackage

/* rtl/ucc_link_if.sv */
// Register port between the controller and the configuration block.
// Assumes both ends run on the same clock; strobes are one cycle.
`timescale 1ns/1ps
interface ucc_link_if;
    logic sel;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    modport dev (input sel, input write, input addr, input wdata, output ack, output rdata);
    modport host (output sel, output write, output addr, output wdata, input ack, input rdata);
endinterface

/* rtl/ucc_device.sv */
// USB client configuration registers: index/data port, input control,
// endpoint toggles and the EP4 NAK decision.
// Assumes the link and the USB core signals are synchronous to CLK_SYS.
`timescale 1ns/1ps
module ucc_device import ucc_pkg::*; (
    input wire logic CLK_SYS,
    input wire logic RST,
    ucc_link_if.dev LINK,
    input wire logic [3:0] EP_DONE,
    input wire logic IN_TOKEN_EP4,
    input wire logic TX_FIFO_VALID,
    input wire logic TX_FIFO_NONEMPTY,
    output logic STRING_ENABLE,
    output logic [7:0] STRING_INDEX_VENDOR,
    output logic [7:0] STRING_INDEX_PRODUCT,
    output logic [7:0] MAX_CURRENT,
    output logic [3:0] TOGGLE,
    output logic TX_QUALIFY_MODE,
    output logic EP4_NAK,
    output logic EP4_SEND,
    output logic DIFF_RX_ENABLE,
    output logic BULK_MODE,
    output logic WAKEUP_N
);

    logic [7:0] ext_index;
    logic rsvd_ext;
    logic [2:0] tog_rsvd;
    logic [3:0] in_rsvd;
    logic [1:0] tog_wr_pipe;
    logic [3:0] tog_val_s1;
    logic [3:0] tog_val_s2;
    logic [7:0] ext_rd;

    // Address decode for the register port
    wire hit_index = (LINK.addr == ADDR_EXT_INDEX);
    wire hit_data = (LINK.addr == ADDR_EXT_DATA);
    wire hit_in = (LINK.addr == ADDR_INPUT_CTL);
    wire do_wr = LINK.sel & LINK.write;
    wire wr_index = do_wr & hit_index;
    wire wr_data = do_wr & hit_data;
    wire wr_in = do_wr & hit_in;

    // Data port writes go to the register picked by the index
    wire wr_string = wr_data & (ext_index == IDX_STRING);
    wire wr_max_cur = wr_data & (ext_index == IDX_MAX_CUR);
    wire wr_toggle = wr_data & (ext_index == IDX_TOGGLE);
    wire wr_rsvd = wr_data & (ext_index == IDX_RSVD);
    wire wr_fifo = wr_data & (ext_index == IDX_FIFO_CTL);
    wire [7:0] wbyte = LINK.wdata[7:0];

    // Current above the legal code is held at the limit
    wire [7:0] next_max_cur = (wbyte > MAX_CUR_LIMIT) ? MAX_CUR_LIMIT : wbyte;

    // EP4 answer: qualify mode waits for the valid flag, plain mode for any data
    wire ep4_nak_cond = TX_QUALIFY_MODE ? !TX_FIFO_VALID : !TX_FIFO_NONEMPTY;

    wire [15:0] in_word = {9'h000, DIFF_RX_ENABLE, in_rsvd[3:2], BULK_MODE, WAKEUP_N, in_rsvd[1:0]};

    // Extended register readback through the data port
    always_comb begin
        case (ext_index)
            IDX_STRING: ext_rd = {7'h00, STRING_ENABLE};
            IDX_MAX_CUR: ext_rd = MAX_CURRENT;
            IDX_TOGGLE: ext_rd = {TOGGLE, tog_rsvd[2:1], 1'h0, tog_rsvd[0]};
            IDX_RSVD: ext_rd = {7'h00, rsvd_ext};
            IDX_FIFO_CTL: ext_rd = {7'h00, TX_QUALIFY_MODE};
            default: ext_rd = 8'h00;
        endcase
    end

    // Unmapped addresses, the reserved word among them, read as zero
    wire [15:0] rd_word = hit_index ? {8'h00, ext_index} :
                          hit_data ? {8'h00, ext_rd} :
                          hit_in ? in_word : 16'h0000;

    // Every access is answered one cycle after the select
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            LINK.ack <= 1'h0;
            LINK.rdata <= 16'h0000;
        end else begin
            LINK.ack <= LINK.sel;
            if (LINK.sel && !LINK.write) begin
                LINK.rdata <= rd_word;
            end
        end
    end

    // Index register
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ext_index <= RST_INDEX;
        end else if (wr_index) begin
            ext_index <= wbyte;
        end
    end

    // String enable and the string indexes it reports
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            STRING_ENABLE <= RST_STRING[BIT_STRING_EN];
            STRING_INDEX_VENDOR <= 8'h00;
            STRING_INDEX_PRODUCT <= 8'h00;
        end else begin
            if (wr_string) begin
                STRING_ENABLE <= wbyte[BIT_STRING_EN];
            end
            STRING_INDEX_VENDOR <= STRING_ENABLE ? STR_IDX_VENDOR : 8'h00;
            STRING_INDEX_PRODUCT <= STRING_ENABLE ? STR_IDX_PRODUCT : 8'h00;
        end
    end

    // Maximum current field, in units of 2 mA
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            MAX_CURRENT <= RST_MAX_CUR;
        end else if (wr_max_cur) begin
            MAX_CURRENT <= next_max_cur;
        end
    end

    // Reserved byte and FIFO qualify mode
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rsvd_ext <= RST_RSVD_EXT[0];
            TX_QUALIFY_MODE <= RST_FIFO_CTL[BIT_TXQ_MODE];
        end else begin
            if (wr_rsvd) begin
                rsvd_ext <= wbyte[0];
            end
            if (wr_fifo) begin
                TX_QUALIFY_MODE <= wbyte[BIT_TXQ_MODE];
            end
        end
    end

    // Toggle writes travel two stages before reaching the USB-side copy,
    // so a readback right after a write still shows the old value
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tog_wr_pipe <= 2'h0;
            tog_val_s1 <= 4'h0;
            tog_val_s2 <= 4'h0;
            tog_rsvd <= 3'h0;
        end else begin
            tog_wr_pipe <= {tog_wr_pipe[0], wr_toggle};
            tog_val_s1 <= wbyte[TOGGLE_LSB +: 4];
            tog_val_s2 <= tog_val_s1;
            if (wr_toggle) begin
                tog_rsvd <= {wbyte[3:2], wbyte[0]};
            end
        end
    end

    // USB-side toggles: bit 0..3 are EP1..EP4, flipped on each completed
    // transaction; a landing software write overrides a same-cycle flip
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            TOGGLE <= RST_TOGGLE[TOGGLE_LSB +: 4];
        end else if (tog_wr_pipe[1]) begin
            TOGGLE <= tog_val_s2;
        end else begin
            TOGGLE <= TOGGLE ^ EP_DONE;
        end
    end

    // Answer to an IN token on endpoint four
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            EP4_NAK <= 1'h0;
            EP4_SEND <= 1'h0;
        end else begin
            EP4_NAK <= IN_TOKEN_EP4 & ep4_nak_cond;
            EP4_SEND <= IN_TOKEN_EP4 & !ep4_nak_cond;
        end
    end

    // Input control: receiver enable, transfer type, wake-up request
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            DIFF_RX_ENABLE <= RST_INPUT_CTL[BIT_DIFF_RX];
            BULK_MODE <= RST_INPUT_CTL[BIT_BULK];
            WAKEUP_N <= RST_INPUT_CTL[BIT_WAKE_N];
            in_rsvd <= {RST_INPUT_CTL[5:4], RST_INPUT_CTL[1:0]};
        end else if (wr_in) begin
            DIFF_RX_ENABLE <= LINK.wdata[BIT_DIFF_RX];
            BULK_MODE <= LINK.wdata[BIT_BULK];
            WAKEUP_N <= LINK.wdata[BIT_WAKE_N];
            in_rsvd <= {LINK.wdata[5:4], LINK.wdata[1:0]};
        end
    end

endmodule

/* verif/ucc_link_checker.sv */
// Concurrent checks on the register port between controller and configuration block.
// Assumes it sees the link interface signals as plain inputs, on the one system clock.
`timescale 1ns/1ps
module ucc_link_checker import ucc_pkg::*; (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic sel,
    input wire logic write,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic [7:0] idx;
    logic [3:0] since_tog;
    // Decoded accesses; the index copy mirrors what the device steers by
    wire logic wr_idx = sel && write && addr == ADDR_EXT_INDEX;
    wire logic wr_ext = sel && write && addr == ADDR_EXT_DATA;
    wire logic rd_tog = sel && !write && addr == ADDR_EXT_DATA && idx == IDX_TOGGLE;
    // Index copy, and cycles since the last toggle write (saturates, so no wrap hides a fast read)
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            idx <= RST_INDEX;
            since_tog <= 4'hF;
        end else begin
            if (wr_idx) idx <= wdata[7:0];
            if (wr_ext && idx == IDX_TOGGLE) since_tog <= 4'h0;
            else if (since_tog != 4'hF) since_tog <= since_tog + 4'h1;
        end
    end
    a_ack_follows_sel: assert property (sel |=> ack) else $error("ack missing after select");
    a_ack_has_cause: assert property (ack |-> $past(sel)) else $error("ack without select");
    a_sel_spacing: assert property (ack |-> !sel ##1 !sel) else $error("select too soon after ack");
    a_rdata_on_ack: assert property ($changed(rdata) |-> ack) else $error("read data moved without ack");
    a_inctl_rsvd_zero: assert property (sel && write && addr == ADDR_INPUT_CTL |->
        (wdata & ~WMASK_INPUT_CTL) == 16'h0000) else $error("input control reserved bits set");
    a_rsvd_word_zero: assert property (sel && write && addr == ADDR_RSVD_A |-> wdata == 16'h0000)
        else $error("reserved word written nonzero");
    a_toggle_rsvd_zero: assert property (wr_ext && idx == IDX_TOGGLE |-> wdata[3:0] == 4'h0)
        else $error("toggle reserved bits set");
    a_rsvd_ext_zero: assert property (wr_ext && idx == IDX_RSVD |-> wdata[7:0] == 8'h00)
        else $error("reserved extended byte nonzero");
    a_max_cur_limit: assert property (wr_ext && idx == IDX_MAX_CUR |-> wdata[7:0] <= MAX_CUR_LIMIT)
        else $error("max current above limit");
    a_thr_nonzero: assert property (wr_ext && idx == IDX_TXAE_THR |-> wdata[7:0] != 8'h00)
        else $error("almost-empty threshold zero");
    a_toggle_settle: assert property (rd_tog |-> since_tog >= 4'hC)
        else $error("toggle read too soon after write");
    c_toggle_read: cover property (rd_tog);
    c_max_cur_write: cover property (wr_ext && idx == IDX_MAX_CUR);
    c_inctl_write: cover property (sel && write && addr == ADDR_INPUT_CTL);
endmodule

/* verif/tb_top.sv */
// Testbench: controller and configuration block joined by the link, driven over APB.
// Assumes the package constants and the controller's APB map; one 10 MHz clock.
`timescale 1ns/1ps
module tb_top import ucc_pkg::*;;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] idx;
        logic [15:0] wdata;
        logic [15:0] rd;
        logic [31:0] outs;
    } ucc_row_s;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [3:0] ep_done = 4'h0;
    logic in_token = 1'b0, fifo_valid = 1'b0, fifo_nonempty = 1'b0;
    logic string_enable, tx_qualify_mode, ep4_nak, ep4_send, diff_rx_enable, bulk_mode, wakeup_n;
    logic [7:0] string_index_vendor, string_index_product, max_current;
    logic [3:0] toggle;
    int bad_count = 0;
    int n_compared = 0;
    // Outputs packed as {SE, vendor, product, current, qualify, rx, bulk, wake_n}
    wire logic [31:0] outs = {3'b000, string_enable, string_index_vendor, string_index_product, max_current,
        tx_qualify_mode, diff_rx_enable, bulk_mode, wakeup_n};
    ucc_row_s rows [11] = '{
        '{ADDR_EXT_DATA, IDX_STRING, 16'h0000, 16'h0000, 32'h00000FA3},
        '{ADDR_EXT_DATA, IDX_STRING, 16'h0001, 16'h0001, 32'h10102FA3},
        '{ADDR_EXT_DATA, IDX_MAX_CUR, 16'h0064, 16'h0064, 32'h10102643},
        '{ADDR_EXT_DATA, IDX_MAX_CUR, 16'h00FF, 16'h00FA, 32'h10102FA3},
        '{ADDR_EXT_DATA, IDX_FIFO_CTL, 16'h0001, 16'h0001, 32'h10102FAB},
        '{ADDR_EXT_DATA, IDX_RSVD, 16'h00FF, 16'h0000, 32'h10102FAB},
        '{ADDR_INPUT_CTL, 8'h00, 16'hFFFF, 16'h004C, 32'h10102FAF},
        '{ADDR_INPUT_CTL, 8'h00, 16'h0000, 16'h0000, 32'h10102FA8},
        '{ADDR_EXT_DATA, IDX_FIFO_CTL, 16'h0000, 16'h0000, 32'h10102FA0},
        '{ADDR_RSVD_A, 8'h00, 16'hFFFF, 16'h0000, 32'h10102FA0},
        '{ADDR_EXT_DATA, IDX_TXAE_THR, 16'h0000, 16'h0000, 32'h10102FA0}
    };
    ucc_link_if ucc_link_if_i ();
    ucc_device ucc_device_i (.CLK_SYS(clk_sys), .RST(rst), .LINK(ucc_link_if_i.dev), .EP_DONE(ep_done),
        .IN_TOKEN_EP4(in_token), .TX_FIFO_VALID(fifo_valid), .TX_FIFO_NONEMPTY(fifo_nonempty),
        .STRING_ENABLE(string_enable), .STRING_INDEX_VENDOR(string_index_vendor),
        .STRING_INDEX_PRODUCT(string_index_product), .MAX_CURRENT(max_current), .TOGGLE(toggle),
        .TX_QUALIFY_MODE(tx_qualify_mode), .EP4_NAK(ep4_nak), .EP4_SEND(ep4_send),
        .DIFF_RX_ENABLE(diff_rx_enable), .BULK_MODE(bulk_mode), .WAKEUP_N(wakeup_n));
    ucc_host ucc_host_i (.CLK_SYS(clk_sys), .RST(rst), .LINK(ucc_link_if_i.host), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
    ucc_link_checker ucc_link_checker_i (.CLK_SYS(clk_sys), .RST(rst), .sel(ucc_link_if_i.sel),
        .write(ucc_link_if_i.write), .addr(ucc_link_if_i.addr), .wdata(ucc_link_if_i.wdata),
        .ack(ucc_link_if_i.ack), .rdata(ucc_link_if_i.rdata));
    // 100 ns clock
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One APB transfer; ready, read data and error are taken at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One device access through the controller, polling busy under a bound
    task automatic dev_cmd(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [15:0] r);
        logic [31:0] q;
        logic e;
        int n;
        apb(1'b1, HOST_ADDR, {16'h0000, a}, q, e);
        apb(1'b1, HOST_WDATA, {16'h0000, d}, q, e);
        apb(1'b1, HOST_CTRL, {30'h0, wr, 1'b1}, q, e);
        n = 0;
        do begin
            apb(1'b0, HOST_RESULT, 32'h0, q, e);
            n++;
        end while (q[16] !== 1'b0 && n < 100);
        if (n >= 100) bad_count++;
        r = q[15:0];
    endtask
    task automatic ext_cmd(input logic wr, input logic [7:0] ix, input logic [15:0] d, output logic [15:0] r);
        dev_cmd(1'b1, ADDR_EXT_INDEX, {8'h00, ix}, r);
        dev_cmd(wr, ADDR_EXT_DATA, d, r);
    endtask
    // Let a registered output settle, then sample mid-cycle
    task automatic settle();
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // Watchdog: the sequence needs well under 1 ms
    initial begin
        #5000000;
        bad_count++;
        complete_run();
    end
    initial begin
        logic [15:0] r;
        logic [31:0] q;
        logic e;
        logic nak;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
        check(outs, 32'h10102FA3);
        dev_cmd(1'b0, ADDR_INPUT_CTL, 16'h0000, r);
        check({16'h0, r}, {16'h0, RST_INPUT_CTL});
        ext_cmd(1'b0, IDX_MAX_CUR, 16'h0000, r);
        check({16'h0, r}, {24'h0, RST_MAX_CUR});
        foreach (rows[i]) begin
            if (rows[i].addr == ADDR_EXT_DATA) dev_cmd(1'b1, ADDR_EXT_INDEX, {8'h00, rows[i].idx}, r);
            dev_cmd(1'b1, rows[i].addr, rows[i].wdata, r);
            dev_cmd(1'b0, rows[i].addr, 16'h0000, r);
            check({16'h0, r}, {16'h0, rows[i].rd});
            check(outs, rows[i].outs);
        end
        // Toggle write with reserved bits set, then a read that reaches the guard just as it runs out, so it is not held
        ext_cmd(1'b1, IDX_TOGGLE, 16'h00FF, r);
        check({28'h0, toggle}, 32'h0000000F);
        dev_cmd(1'b0, ADDR_EXT_DATA, 16'h0000, r);
        check({16'h0, r}, 32'h000000F0);
        @(posedge clk_sys);
        ep_done <= 4'h5;
        @(posedge clk_sys);
        ep_done <= 4'h0;
        @(negedge clk_sys);
        check({28'h0, toggle}, 32'h0000000A);
        dev_cmd(1'b0, ADDR_EXT_DATA, 16'h0000, r);
        check({16'h0, r}, 32'h000000A0);
        // Every mode, valid and fill combination for the EP4 answer
        for (int i = 0; i < 8; i++) begin
            ext_cmd(1'b1, IDX_FIFO_CTL, {15'h0, i[2]}, r);
            @(posedge clk_sys);
            fifo_valid <= i[1];
            fifo_nonempty <= i[0];
            in_token <= 1'b1;
            @(posedge clk_sys);
            in_token <= 1'b0;
            @(negedge clk_sys);
            nak = i[2] ? !i[1] : !i[0];
            check({30'h0, ep4_nak, ep4_send}, {30'h0, nak, !nak});
        end
        // Interrupt: raise, mask, unmask, clear
        apb(1'b1, HOST_INT_STAT, 32'h00000007, q, e);
        apb(1'b1, HOST_INT_MASK, 32'h00000001, q, e);
        dev_cmd(1'b0, ADDR_INPUT_CTL, 16'h0000, r);
        settle();
        check({31'h0, irq}, 32'h1);
        apb(1'b1, HOST_INT_MASK, 32'h00000000, q, e);
        settle();
        check({31'h0, irq}, 32'h0);
        apb(1'b1, HOST_INT_MASK, 32'h00000001, q, e);
        apb(1'b1, HOST_INT_STAT, 32'h00000001, q, e);
        settle();
        check({31'h0, irq}, 32'h0);
        // Unmapped controller address is refused
        apb(1'b0, 8'h18, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        // Second reset in mid-run restores defaults
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
        check(outs, 32'h10102FA3);
        check({28'h0, toggle}, 32'h0);
        complete_run();
    end
endmodule
